// ==== rtl/radio_sleep_wake_controller.sv ====
`timescale 1ns/100ps
module radio_sleep_wake_controller #(
    parameter int unsigned TICK_CYCLES = sleep_ctl_pkg::TICK_CYC,
    parameter int unsigned CHAR_CYCLES = sleep_ctl_pkg::CHAR_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic sleep_request_pin,
    input wire logic serial_select_pin,
    input wire sleep_ctl_pkg::busy_t busy,
    input wire logic rx_data,
    input wire logic sync_rx_valid,
    input wire sleep_ctl_pkg::sync_msg_t sync_rx,
    input wire logic sync_req_rx,
    input wire logic relay_heard,
    output logic sync_tx_valid,
    output sleep_ctl_pkg::sync_msg_t sync_tx,
    output logic poll_req,
    output logic awake,
    output logic rx_accept,
    output logic awake_indicator_pin,
    output logic cts_pin
);
    import sleep_ctl_pkg::*;

    // Counter widths cover the full count
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int CW = $clog2(CHAR_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0] ctrl_reg; // Mode and option bits
    logic [15:0] sp_reg; // Own sleep period
    logic [15:0] st_reg; // Own wake time
    logic [15:0] obs_sleep_reg; // Sleep time in use
    logic [15:0] obs_wake_reg; // Wake time in use
    logic [15:0] rdata_reg;
    logic [TW-1:0] tick_cnt_reg;
    logic [CW-1:0] char_cnt_reg; // Pin sleep minimum awake
    logic [15:0] awake_ms_reg; // Time until sleep allowed
    logic [15:0] sleep_ms_reg; // Time until wake
    logic [15:0] wait_ms_reg; // Relay wait / deploy repeat
    logic [3:0] missed_reg; // Consecutive cycles without sync
    logic synced_reg, deploy_reg, got_sync_reg, relay_seen_reg;
    logic [1:0] rq_sync_reg, sel_sync_reg; // Pin synchronisers
    logic rq_prev_reg;
    logic ind_reg, cts_reg, poll_reg, tx_valid_reg;
    sync_msg_t tx_reg;
    power_state_t state_reg, state_next;

    ////////////////////////////////////////////////////////////////////////
    // Decoding
    wire [3:0] mode = ctrl_reg[3:0];
    wire m_pin = mode == MODE_PIN;
    wire m_pw = mode == MODE_CYC_PW;
    wire m_cyc = (mode == MODE_CYC) | m_pw;
    wire m_sync = mode == MODE_SYNC;
    wire sleepy = m_pin | m_cyc | m_sync;
    // Coordinator role is set by software, never elected here
    wire coord = ctrl_reg[C_COORD];
    wire asleep = state_reg == S_ASLEEP;
    // Request pin source
    wire rq_s = ctrl_reg[C_PCFG] ? rq_sync_reg[1] : sel_sync_reg[1];
    wire rq_fall = rq_prev_reg & ~rq_s;
    wire pin_wake = m_pw & rq_fall;
    // Work that blocks sleep
    wire blocked = busy.cmd_mode | busy.api_cmd | busy.remote_cmd
        | (busy.serial_queued & ~busy.rts_hold)
        | busy.radio_pending;
    // Received data counts only while awake
    wire rx_ok = rx_data & ~asleep;
    // One-cycle enable at each millisecond boundary
    wire ms_tick = tick_cnt_reg == TW'(TICK_CYCLES - 1);

    // Wake and sleep decisions
    wire wake_now = asleep & (~sleepy
        | (m_pin & ~rq_s)
        | (~m_pin & sleep_ms_reg == 16'h0000)
        | pin_wake);
    wire hold_awake = blocked
        | (m_pin & (~rq_s | char_cnt_reg != '0))
        | (~m_pin & awake_ms_reg != 16'h0000)
        | (m_pw & ~rq_s)
        // Data arriving as the timer runs out must not race the reload into sleep
        | (m_cyc & rx_ok);
    // Sleep only when nothing holds the device up
    wire sleep_now = ~asleep & sleepy & ~hold_awake;
    // Waking takes priority over sleeping
    assign state_next = wake_now ? S_AWAKE : (sleep_now ? S_ASLEEP : state_reg);

    // Wake length loaded on waking
    wire [15:0] wake_load = m_cyc ? (pin_wake ? st_reg : MIN_AWAKE_MS)
        : ((m_sync & synced_reg & ~coord) ? obs_wake_reg : st_reg);

    // Sleep length, cut back for missed syncs
    wire [15:0] early = (ctrl_reg[C_NOEARLY] | coord) ? 16'h0000
        : {12'h000, missed_reg} * EARLY_STEP_MS;
    wire [15:0] sync_sleep = (early >= obs_sleep_reg) ? 16'h0001 : obs_sleep_reg - early;
    wire [15:0] sl_raw = (m_sync & synced_reg) ? sync_sleep : sp_reg;
    wire [15:0] sleep_load = (sl_raw == 16'h0000) ? 16'h0001 : sl_raw;

    // Sync traffic
    wire sync_hit = sync_rx_valid & m_sync & ~asleep & ~coord & sync_rx.kind == MSG_SYNC;
    wire reject = sync_hit & sync_rx.deploy & ~deploy_reg & synced_reg;
    wire sync_ok = sync_hit & ~reject;
    wire coord_start = wake_now & m_sync & coord;
    wire wait_fire = ms_tick & wait_ms_reg == 16'h0001 & m_sync & coord & ~asleep
        & ~relay_seen_reg;
    wire req_fire = wake_now & m_sync & ~coord & (~synced_reg
        | (ctrl_reg[C_NONC] & missed_reg >= MISS_LIMIT));
    wire reply_fire = sync_req_rx & m_sync & synced_reg & ~asleep;
    // One message at most leaves per cycle
    wire any_tx = coord_start | wait_fire | reject | sync_ok | reply_fire | req_fire;

    // Message to send, highest priority first
    sync_msg_t tx_next;
    assign tx_next = coord_start ? '{MSG_SYNC, deploy_reg, sp_reg, st_reg}
        : wait_fire ? '{MSG_SYNC, deploy_reg, obs_sleep_reg, obs_wake_reg}
        : reject ? '{MSG_CORR, 1'b0, obs_sleep_reg, obs_wake_reg}
        : sync_ok ? '{MSG_SYNC, sync_rx.deploy, sync_rx.sleep_ms, sync_rx.wake_ms}
        : reply_fire ? '{MSG_SYNC, 1'b0, obs_sleep_reg, obs_wake_reg}
        : '{MSG_REQ, 1'b0, sp_reg, st_reg};

    // Read data select; unmapped reads zero
    wire [15:0] rd_mux = (reg_addr == REG_CTRL) ? ctrl_reg
        : (reg_addr == REG_SLEEP) ? sp_reg
        : (reg_addr == REG_WAKE) ? st_reg
        : (reg_addr == REG_OBS_SLEEP) ? obs_sleep_reg
        : (reg_addr == REG_OBS_WAKE) ? obs_wake_reg
        : (reg_addr == REG_STATUS) ? {9'h000, missed_reg, deploy_reg, synced_reg, asleep}
        : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata = rdata_reg;
    assign awake = ~asleep;
    assign rx_accept = ~asleep;
    assign awake_indicator_pin = ind_reg;
    assign cts_pin = cts_reg;
    assign poll_req = poll_reg;
    assign sync_tx_valid = tx_valid_reg;
    assign sync_tx = tx_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= CTRL_RST;
            sp_reg <= SP_RST;
            st_reg <= ST_RST;
        end else if (reg_wr) begin
            // Writable control and own times
            if (reg_addr == REG_CTRL) ctrl_reg <= {5'h00, reg_wdata[10:0]};
            if (reg_addr == REG_SLEEP) sp_reg <= reg_wdata;
            if (reg_addr == REG_WAKE) st_reg <= reg_wdata;
        end
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) rdata_reg <= 16'h0000;
        else rdata_reg <= reg_rd ? rd_mux : 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge history
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rq_sync_reg <= 2'b00;
            sel_sync_reg <= 2'b00;
            rq_prev_reg <= 1'b0;
        end else begin
            rq_sync_reg <= {rq_sync_reg[0], sleep_request_pin};
            sel_sync_reg <= {sel_sync_reg[0], serial_select_pin};
            rq_prev_reg <= rq_s;
        end
    end

    // Millisecond tick divider
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) tick_cnt_reg <= '0;
        else tick_cnt_reg <= ms_tick ? '0 : tick_cnt_reg + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state and indicator pins
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= S_AWAKE;
            ind_reg <= 1'b0;
            cts_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ind_reg <= ctrl_reg[C_IND] & (state_next == S_AWAKE);
            cts_reg <= ctrl_reg[C_CTS] & (state_next == S_ASLEEP);
        end
    end

    // Pin sleep: stay up one character after waking
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) char_cnt_reg <= '0;
        else if (wake_now) char_cnt_reg <= CW'(CHAR_CYCLES);
        else if (char_cnt_reg != '0) char_cnt_reg <= char_cnt_reg - 1'b1;
    end

    // Wake timer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) awake_ms_reg <= 16'h0000;
        else if (wake_now) awake_ms_reg <= wake_load;
        else if (sync_ok) awake_ms_reg <= sync_rx.wake_ms;
        else if (m_cyc & rx_ok) awake_ms_reg <= st_reg;
        else if (ms_tick & ~asleep & awake_ms_reg != 16'h0000)
            awake_ms_reg <= awake_ms_reg - 16'h0001;
    end

    // Sleep timer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) sleep_ms_reg <= 16'h0000;
        else if (sleep_now) sleep_ms_reg <= sleep_load;
        else if (ms_tick & asleep & sleep_ms_reg != 16'h0000)
            sleep_ms_reg <= sleep_ms_reg - 16'h0001;
    end

    // Poll request at each cyclic wake not caused by the pin
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) poll_reg <= 1'b0;
        else poll_reg <= wake_now & m_cyc & ~pin_wake;
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisation state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            synced_reg <= 1'b0;
            got_sync_reg <= 1'b0;
            missed_reg <= 4'h0;
            obs_sleep_reg <= SP_RST;
            obs_wake_reg <= ST_RST;
        end else if (coord_start) begin
            // Coordinator publishes its times at wake start; later resends and replies repeat these
            synced_reg <= 1'b1;
            obs_sleep_reg <= sp_reg;
            obs_wake_reg <= st_reg;
        end else if (sync_ok) begin
            // Adopt network times
            synced_reg <= 1'b1;
            got_sync_reg <= 1'b1;
            missed_reg <= 4'h0;
            obs_sleep_reg <= sync_rx.sleep_ms;
            obs_wake_reg <= sync_rx.wake_ms;
        end else if (wake_now) begin
            got_sync_reg <= 1'b0;
        end else if (sleep_now & m_sync & synced_reg & ~coord & ~got_sync_reg
                     & missed_reg != 4'hF) begin
            missed_reg <= missed_reg + 4'h1;
        end
    end

    // Deployment mode and relay watch
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            deploy_reg <= 1'b1;
            relay_seen_reg <= 1'b0;
            wait_ms_reg <= 16'h0000;
        end else begin
            // Leaves deployment on a relay or a settled sync
            if (ctrl_reg[C_NODEP] | (relay_heard & ~asleep) | (sync_ok & ~sync_rx.deploy))
                deploy_reg <= 1'b0;
            if (coord_start) relay_seen_reg <= 1'b0;
            else if (relay_heard & ~asleep) relay_seen_reg <= 1'b1;
            // Repeat in deployment, else a single resend
            if (coord_start) wait_ms_reg <= RESYNC_MS;
            else if (wait_fire) wait_ms_reg <= deploy_reg ? RESYNC_MS : 16'h0000;
            else if (ms_tick & wait_ms_reg != 16'h0000) wait_ms_reg <= wait_ms_reg - 16'h0001;
        end
    end

    // Outgoing sync message
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_valid_reg <= 1'b0;
            tx_reg <= '{MSG_SYNC, 1'b0, 16'h0000, 16'h0000};
        end else begin
            tx_valid_reg <= any_tx;
            if (any_tx) tx_reg <= tx_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // All checks run on the one clock and rest during reset
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // Request high with nothing pending must reach sleep
    property p_pin_follow;
        m_pin & ~asleep & rq_s & char_cnt_reg == '0 & ~blocked |=> asleep;
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin sleep not entered");

    // Pending work keeps the device awake
    property p_block;
        ~asleep & blocked |=> ~asleep;
    endproperty
    a_block: assert property (p_block) else $error("slept while busy");

    // Indicator tracks the power state while enabled
    property p_ind;
        $past(ctrl_reg[C_IND]) |-> awake_indicator_pin == ~asleep;
    endproperty
    a_ind: assert property (p_ind) else $error("indicator wrong");

    // Flow control shows sleep while enabled
    property p_cts;
        $past(ctrl_reg[C_CTS]) |-> cts_pin == asleep;
    endproperty
    a_cts: assert property (p_cts) else $error("cts wrong");

    // A falling request wakes for the full wake time
    property p_fall;
        m_pw & asleep & rq_fall |=> ~asleep ##0 awake_ms_reg == $past(st_reg);
    endproperty
    a_fall: assert property (p_fall) else $error("pin wake missed");

    // Timer wakes poll and keep the short minimum awake time
    property p_poll;
        m_cyc & wake_now & ~pin_wake |=> awake_ms_reg == MIN_AWAKE_MS ##0 poll_req;
    endproperty
    a_poll: assert property (p_poll) else $error("poll wake wrong");

    // Received data restarts the wake timer
    property p_rx;
        m_cyc & rx_ok & ~wake_now |=> awake_ms_reg == $past(st_reg) ##1 ~asleep;
    endproperty
    a_rx: assert property (p_rx) else $error("rx restart wrong");

    // An unsynced node asks for sync at wake start
    property p_req;
        wake_now & m_sync & ~coord & ~synced_reg |=> sync_tx_valid & sync_tx.kind == MSG_REQ;
    endproperty
    a_req: assert property (p_req) else $error("no sync request");

    // A deployment sync reaching a synced node out of deployment is answered with a correction
    property p_corr;
        reject & ~coord_start & ~wait_fire |=> sync_tx_valid & sync_tx.kind == MSG_CORR;
    endproperty
    a_corr: assert property (p_corr) else $error("no corrective sync");
endmodule

// ==== rtl/sleep_ctl_pkg.sv ====
package sleep_ctl_pkg;
    // Clock rate and derived cycle counts
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TICK_MS = 1; // Timer tick period in ms
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned CHAR_NS = 87_000; // One UART character in ns
    localparam int unsigned CHAR_CYC = (CHAR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Times in ms
    localparam logic [15:0] MIN_AWAKE_MS = 16'h001E; // Poll and response window
    localparam logic [15:0] RESYNC_MS = 16'h000A; // Relay wait and deploy rate
    localparam logic [15:0] EARLY_STEP_MS = 16'h0002; // Sleep cut per missed sync
    localparam logic [3:0] MISS_LIMIT = 4'h6; // Missed cycles before request
    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_SLEEP = 4'h1;
    localparam logic [3:0] REG_WAKE = 4'h2;
    localparam logic [3:0] REG_OBS_SLEEP = 4'h3;
    localparam logic [3:0] REG_OBS_WAKE = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    // Control field positions (mode sits in bits 3..0)
    localparam int C_IND = 4;
    localparam int C_CTS = 5;
    localparam int C_PCFG = 6;
    localparam int C_COORD = 7;
    localparam int C_NONC = 8;
    localparam int C_NODEP = 9;
    localparam int C_NOEARLY = 10;
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0040;
    localparam logic [15:0] SP_RST = 16'h0064;
    localparam logic [15:0] ST_RST = 16'h07D0;
    // Sleep mode codes
    localparam logic [3:0] MODE_PIN = 4'h1;
    localparam logic [3:0] MODE_CYC = 4'h4;
    localparam logic [3:0] MODE_CYC_PW = 4'h5;
    localparam logic [3:0] MODE_SYNC = 4'h8;

    typedef enum logic [1:0] {S_AWAKE = 2'b01, S_ASLEEP = 2'b10} power_state_t;
    typedef enum logic [1:0] {MSG_SYNC = 2'h0, MSG_REQ = 2'h1, MSG_CORR = 2'h2} msg_kind_t;

    // Sync message as carried to and from the radio
    typedef struct packed {
        msg_kind_t kind;
        logic deploy;
        logic [15:0] sleep_ms;
        logic [15:0] wake_ms;
    } sync_msg_t;

    // Work that keeps the device awake; rts_hold instead releases serial_queued
    typedef struct packed {
        logic cmd_mode;
        logic api_cmd;
        logic remote_cmd;
        logic serial_queued;
        logic rts_hold;
        logic radio_pending;
    } busy_t;
endpackage

// ==== tb/host_peer_model.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Host pins and peer radio traffic seen by the sleep controller
module host_peer_model (
    input wire logic ref_clk,
    output logic sleep_request_pin,
    output logic serial_select_pin,
    output logic sync_rx_valid,
    output sleep_ctl_pkg::sync_msg_t sync_rx,
    output logic sync_req_rx,
    output logic relay_heard
);
    import sleep_ctl_pkg::*;

    // Idle levels at time zero; the message bus carries noise when idle
    initial begin
        sleep_request_pin = 1'b0;
        serial_select_pin = 1'b0;
        sync_rx_valid = 1'b0;
        sync_rx = sync_msg_t'(35'h5_A5A5_A5A5);
        sync_req_rx = 1'b0;
        relay_heard = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host moves one sleep pin just after an edge and holds it there
    task automatic set_pin(input logic sel, input logic lvl);
        @(posedge ref_clk);
        if (sel) begin
            serial_select_pin <= lvl;
        end else begin
            sleep_request_pin <= lvl;
        end
    endtask

    // Peer broadcasts one sync carrying its sleep and wake times
    task automatic send_sync(input msg_kind_t k, input logic dep, input logic [15:0] sp,
                             input logic [15:0] st);
        @(posedge ref_clk);
        sync_rx_valid <= 1'b1;
        sync_rx <= '{k, dep, sp, st};
        @(posedge ref_clk);
        sync_rx_valid <= 1'b0;
        // Released bus shows the inverse so stale contents are never reused
        sync_rx <= sync_msg_t'(~{k, dep, sp, st});
    endtask

    // Peer pulses a relay of our sync or a sync request for one cycle
    task automatic pulse_peer(input logic relay);
        @(posedge ref_clk);
        if (relay) begin
            relay_heard <= 1'b1;
        end else begin
            sync_req_rx <= 1'b1;
        end
        @(posedge ref_clk);
        relay_heard <= 1'b0;
        sync_req_rx <= 1'b0;
    endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the sleep and wake controller
module tb_top;
    import sleep_ctl_pkg::*;
    localparam int unsigned TICKS = 20; // Short ms tick
    localparam int unsigned CHARS = 8; // Short character time
    typedef struct packed {logic awk; logic ind; logic cts;} pin_exp_t;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic sleep_request_pin, serial_select_pin, sync_rx_valid, sync_req_rx, relay_heard;
    sync_msg_t sync_rx, sync_tx;
    busy_t busy = '0;
    logic rx_data = 1'b0; // Received payload pulse
    logic sync_tx_valid, poll_req, awake, rx_accept, awake_indicator_pin, cts_pin;
    logic [15:0] rd_q[$]; // Expected read data
    pin_exp_t st_q[$]; // Expected pin states at each awake change
    msg_kind_t tx_q[$]; // Expected outgoing message kinds
    int miscompares = 0;
    int num_checks = 0;
    logic watch = 1'b0; // Awake changes are checked only while set
    logic rd_d = 1'b0;
    logic prev_awake = 1'b1;
    logic [15:0] rnd;
    int n;

    // Free running 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    radio_sleep_wake_controller #(.TICK_CYCLES(TICKS), .CHAR_CYCLES(CHARS))
        radio_sleep_wake_controller_i (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_request_pin(sleep_request_pin), .serial_select_pin(serial_select_pin),
        .busy(busy), .rx_data(rx_data), .sync_rx_valid(sync_rx_valid), .sync_rx(sync_rx),
        .sync_req_rx(sync_req_rx), .relay_heard(relay_heard), .sync_tx_valid(sync_tx_valid),
        .sync_tx(sync_tx), .poll_req(poll_req), .awake(awake), .rx_accept(rx_accept),
        .awake_indicator_pin(awake_indicator_pin), .cts_pin(cts_pin));

    host_peer_model host_peer_model_i (.ref_clk(ref_clk), .sleep_request_pin(sleep_request_pin),
        .serial_select_pin(serial_select_pin), .sync_rx_valid(sync_rx_valid), .sync_rx(sync_rx),
        .sync_req_rx(sync_req_rx), .relay_heard(relay_heard));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Word results
    task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Pin state results
    task automatic cmp_pins(input pin_exp_t e, input pin_exp_t g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected awake_ind_cts expected %b seen %b", e, g);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Register bus master: one-cycle strobes launched just after an edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        rd_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    // Bounded wait for a given awake level
    task automatic wait_awake(input logic lvl, input int bound, output int cnt);
        for (cnt = 0; cnt < bound; cnt++) begin
            @(posedge ref_clk);
            if (awake === lvl) begin
                return;
            end
        end
        miscompares++;
        $display("unexpected awake expected %b seen %b", lvl, awake);
        report_and_stop();
    endtask

    // Bounded wait until every noted message kind has been seen
    task automatic wait_tx(input int bound);
        for (int i = 0; i < bound && tx_q.size() > 0; i++) begin
            @(posedge ref_clk);
        end
        cmp_word("tx_left", 16'h0000, 16'(tx_q.size()));
        if (tx_q.size() > 0) begin
            report_and_stop();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitors take the oldest note whenever a result appears
    always @(posedge ref_clk) begin
        rd_d <= reg_rd;
        prev_awake <= awake;
        if (rd_d) begin
            cmp_word("reg_rdata", rd_q.pop_front(), reg_rdata);
        end
        if (watch && awake !== prev_awake) begin
            if (st_q.size() == 0) begin
                miscompares++;
                $display("unexpected awake expected %b seen %b", prev_awake, awake);
            end else begin
                cmp_pins(st_q.pop_front(), {awake, awake_indicator_pin, cts_pin});
            end
        end
        // Relays may also appear; only noted kinds are compared
        if (sync_tx_valid === 1'b1 && tx_q.size() > 0) begin
            cmp_word("sync_kind", 16'(tx_q.pop_front()), 16'(sync_tx.kind));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rnd = 16'($urandom(32'hf152_eb6a));
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        // Reset values, unmapped place, random write and read back
        rd(REG_CTRL, CTRL_RST);
        rd(REG_SLEEP, SP_RST);
        rd(REG_WAKE, ST_RST);
        rd(4'hF, 16'h0000);
        rnd = 16'($urandom());
        wr(REG_SLEEP, rnd);
        rd(REG_SLEEP, rnd);
        // Short own times so every wake below ends within the bench's waits
        wr(REG_SLEEP, 16'h0032);
        wr(REG_WAKE, 16'h0003);
        // Pin sleep with indicator and flow control enabled
        wr(REG_CTRL, 16'h0071);
        watch <= 1'b1;
        busy.cmd_mode <= 1'b1;
        host_peer_model_i.set_pin(1'b0, 1'b1);
        repeat (40) @(posedge ref_clk);
        // Serial data queued, nothing else pending
        busy <= busy_t'(6'h04);
        repeat (40) @(posedge ref_clk);
        st_q.push_back('{1'b0, 1'b0, 1'b1});
        busy.rts_hold <= 1'b1;
        wait_awake(1'b0, 40, n);
        busy <= '0;
        st_q.push_back('{1'b1, 1'b1, 1'b0});
        host_peer_model_i.set_pin(1'b0, 1'b0);
        wait_awake(1'b1, 40, n);
        st_q.push_back('{1'b0, 1'b0, 1'b1});
        host_peer_model_i.set_pin(1'b0, 1'b1);
        wait_awake(1'b0, 60, n);
        cmp_word("char_wake", 16'h0001, 16'(n >= CHARS - 2));
        st_q.push_back('{1'b1, 1'b1, 1'b0});
        host_peer_model_i.set_pin(1'b0, 1'b0);
        wait_awake(1'b1, 40, n);
        // Serial select pin takes over when pin config is zero
        wr(REG_CTRL, 16'h0031);
        host_peer_model_i.set_pin(1'b0, 1'b1);
        repeat (30) @(posedge ref_clk);
        st_q.push_back('{1'b0, 1'b0, 1'b1});
        host_peer_model_i.set_pin(1'b1, 1'b1);
        wait_awake(1'b0, 40, n);
        st_q.push_back('{1'b1, 1'b1, 1'b0});
        host_peer_model_i.set_pin(1'b1, 1'b0);
        wait_awake(1'b1, 40, n);
        watch <= 1'b0;
        // Cyclic sleep with pin wake: a short low pulse wakes for the wake time
        wr(REG_CTRL, 16'h0045);
        wait_awake(1'b0, 3000, n);
        host_peer_model_i.set_pin(1'b0, 1'b0);
        @(posedge ref_clk);
        host_peer_model_i.set_pin(1'b0, 1'b1);
        wait_awake(1'b1, 20, n);
        // Data after two ms restarts the wake time, so the wake lasts past four ms
        for (n = 0; n < 4 * TICKS && awake === 1'b1; n++) begin
            rx_data <= (n == 2 * TICKS);
            @(posedge ref_clk);
        end
        rx_data <= 1'b0;
        cmp_word("pin_wake_len", 16'(4 * TICKS), 16'(n));
        wait_awake(1'b0, 800, n);
        // Unsynchronised sync-cyclic node asks for sync, then adopts network times
        wr(REG_SLEEP, 16'h0002);
        wr(REG_WAKE, 16'h0002);
        tx_q.push_back(MSG_REQ);
        wr(REG_CTRL, 16'h0048);
        for (n = 0; n < 3000 && tx_q.size() > 0; n++) begin
            @(posedge ref_clk);
        end
        cmp_word("req_seen", 16'h0000, 16'(tx_q.size()));
        // Sync from a peer still deploying keeps this node in deployment
        host_peer_model_i.send_sync(MSG_SYNC, 1'b1, 16'h0003, 16'h0004);
        rd(REG_OBS_SLEEP, 16'h0003);
        rd(REG_OBS_WAKE, 16'h0004);
        // A synced node answers a sync request
        tx_q.push_back(MSG_SYNC);
        host_peer_model_i.pulse_peer(1'b0);
        wait_tx(20);
        // As coordinator it syncs at wake start and leaves deployment once relayed
        tx_q.push_back(MSG_SYNC);
        wr(REG_CTRL, 16'h00C8);
        wait_tx(3000);
        host_peer_model_i.pulse_peer(1'b1);
        rd(REG_STATUS, 16'h0002);
        repeat (3) @(posedge ref_clk);
        cmp_word("reads_left", 16'h0000, 16'(rd_q.size()));
        report_and_stop();
    end
endmodule
